// ---- src/cas_consts.svh ----
// register offsets, field positions and reset values of the alarm block
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CAS_IDX_SUMMARY      10'h2c0
`define CAS_IDX_FLAGS        10'h2c1
`define CAS_IDX_MASK         10'h2c2
`define CAS_IDX_LANE         10'h2c4
`define CAS_IDX_IRQ_STATUS   10'h2d0
`define CAS_IDX_IRQ_ENABLE   10'h2d1
`define CAS_IDX_IRQ_CLEAR    10'h2d2
`define CAS_IDX_CONTROL      10'h2d3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CAS_BIT_FIFO         5
`define CAS_BIT_PLL          4
`define CAS_BIT_LINK         3
`define CAS_BIT_REALIGN      2
`define CAS_BIT_RSVD1        1
`define CAS_BIT_CLK          0
`define CAS_CTL_LINK_EN      0
`define CAS_CTL_MODE_66B     1

// ----------------------------------------------------------------------
// reset values and field masks
// ----------------------------------------------------------------------
`define CAS_FLAGS_RESET      8'h3f
`define CAS_MASK_RESET       8'h3f
`define CAS_LANE_RESET       8'hff
`define CAS_FLAGS_WMASK      8'h3d
`define CAS_IRQ_BITS         3
`define CAS_IRQ_SUMMARY      0
`define CAS_IRQ_FLAG_SET     1
`define CAS_IRQ_LANE_SET     2

`endif

// ---- src/cas_pkg.sv ----
// types shared by the alarm block
package cas_pkg;

  // ----------------------------------------------------------------------
  // event inputs from the converter core
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       pll_locked;
    logic       link_in_data_state;
    logic       link_startup;
    logic       link_realign;
    logic       sysref_realign;
    logic       divider_mismatch;
    logic [7:0] lane_fifo_error;
  } cas_events_s;

  typedef struct packed {
    logic        write;
    logic [9:0]  index;
    logic [31:0] wdata;
  } cas_access_s;

  typedef enum logic [1:0] {
    CAS_IDLE,
    CAS_ACCESS
  } cas_phase_e;

endpackage : cas_pkg

// ---- src/cas_in_sync.sv ----
// three-stage synchroniser with agreement filter for a bundle of levels
`timescale 1ns/1ps
module cas_in_sync #(
  parameter int WIDTH = 8
) (
  // clock and control
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic             i_enable,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (i_enable) begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change is accepted only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          o_level[g] <= 1'b0;
        end else if (i_enable && (stage2[g] == stage3[g])) begin
          o_level[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule : cas_in_sync

// ---- src/cas_alarm.sv ----
// alarm flags, mask, lane fifo alarms and apb register slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "cas_consts.svh"

// Summary of operation
// - pll unlocked sets pll lock flag bit4
// - 8b10b: enabled link outside data state flags
// - 64b66b: startup or realignment sets link flag
// - sysref clock realignment sets flag bit2
// - divider mismatch between channel pairs sets bit0
// - flags sticky until software writes one; bit1 cannot be cleared
// - every flag reads one after reset
// - link disabled: only clock flag meaningful
// - mask bit one blocks flag from summary
// - mask register resets to 0x3f
// - eight lane fifo alarm bits reset 0xff
// - active lane error sets bit; fifo clear clears all
// - any active lane error sets fifo flag
// - summary high when unmasked flag other than bit1 set
module cas_alarm #(
  parameter int LANES = 8
) (
  // clock, reset, enable
  input  wire logic                 i_clock,
  input  wire logic                 i_srst,
  input  wire logic                 i_clock_en,
  // apb slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [11:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // converter events
  input  wire cas_pkg::cas_events_s i_events,
  input  wire logic [LANES-1:0]     i_lane_active,
  // outputs
  output logic                      o_summary_alarm,
  output logic                      o_serial_link_enable,
  output logic                      o_irq
);

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  localparam int EVW = $bits(cas_pkg::cas_events_s);

  cas_pkg::cas_events_s ev;
  logic [EVW-1:0]       ev_bits;

  cas_in_sync #(
    .WIDTH(EVW)
  ) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_enable(i_clock_en),
    .i_async (i_events),
    .o_level (ev_bits)
  );

  assign ev = cas_pkg::cas_events_s'(ev_bits);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr,
                               input logic [9:0]  idx);
    hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `CAS_IDX_SUMMARY) || hit(addr, `CAS_IDX_FLAGS) ||
             hit(addr, `CAS_IDX_MASK) || hit(addr, `CAS_IDX_LANE) ||
             hit(addr, `CAS_IDX_IRQ_STATUS) ||
             hit(addr, `CAS_IDX_IRQ_ENABLE) ||
             hit(addr, `CAS_IDX_IRQ_CLEAR) || hit(addr, `CAS_IDX_CONTROL);
  endfunction : mapped

  logic wr;
  logic wr_flags;
  logic wr_mask;
  logic wr_lane;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic wr_ctl;

  // single-cycle access phase: pready always high
  assign o_pready   = 1'b1;
  assign o_pslverr  = i_psel && i_penable && !mapped(i_paddr);
  assign wr         = i_clock_en && i_psel && i_penable && i_pwrite &&
                      mapped(i_paddr);
  assign wr_flags   = wr && hit(i_paddr, `CAS_IDX_FLAGS);
  assign wr_mask    = wr && hit(i_paddr, `CAS_IDX_MASK);
  assign wr_lane    = wr && hit(i_paddr, `CAS_IDX_LANE);
  assign wr_irq_en  = wr && hit(i_paddr, `CAS_IDX_IRQ_ENABLE);
  assign wr_irq_clr = wr && hit(i_paddr, `CAS_IDX_IRQ_CLEAR);
  assign wr_ctl     = wr && hit(i_paddr, `CAS_IDX_CONTROL);

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic link_en;
  logic mode_66b;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      link_en  <= 1'b0;
      mode_66b <= 1'b0;
    end else if (wr_ctl) begin
      link_en  <= i_pwdata[`CAS_CTL_LINK_EN];
      mode_66b <= i_pwdata[`CAS_CTL_MODE_66B];
    end
  end

  assign o_serial_link_enable = link_en;

  // ----------------------------------------------------------------------
  // set conditions
  // ----------------------------------------------------------------------
  logic             link_en_q;
  logic             startup_q;
  logic             realign_q;
  logic             link_first;
  logic [LANES-1:0] lane_err;
  logic [7:0]       flag_set;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      link_en_q <= 1'b0;
      startup_q <= 1'b0;
      realign_q <= 1'b0;
    end else if (i_clock_en) begin
      link_en_q <= link_en;
      startup_q <= ev.link_startup;
      realign_q <= ev.link_realign;
    end
  end

  assign link_first = link_en && !link_en_q;
  assign lane_err   = ev.lane_fifo_error[LANES-1:0] & i_lane_active;

  always_comb begin
    flag_set = 8'h00;
    flag_set[`CAS_BIT_PLL] = !ev.pll_locked;
    if (!mode_66b) begin
      flag_set[`CAS_BIT_LINK] = link_en && !ev.link_in_data_state;
    end else begin
      flag_set[`CAS_BIT_LINK] = link_first ||
                                (ev.link_startup && !startup_q) ||
                                (ev.link_realign && !realign_q);
    end
    flag_set[`CAS_BIT_REALIGN] = ev.sysref_realign;
    flag_set[`CAS_BIT_CLK]     = ev.divider_mismatch;
    flag_set[`CAS_BIT_FIFO]    = |lane_err;
    // with the link off only the clock flag is driven
    if (!link_en) begin
      flag_set = flag_set & (8'h01 << `CAS_BIT_CLK);
    end
  end

  // ----------------------------------------------------------------------
  // status flags, mask, lane alarms
  // ----------------------------------------------------------------------
  logic [7:0]       flags;
  logic [7:0]       mask;
  logic [LANES-1:0] lane_alarm;
  logic [7:0]       flag_clr;
  logic             fifo_clr;

  assign flag_clr = wr_flags ? (i_pwdata[7:0] & `CAS_FLAGS_WMASK) : 8'h00;
  assign fifo_clr = flag_clr[`CAS_BIT_FIFO];

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      flags <= `CAS_FLAGS_RESET;
    end else if (i_clock_en) begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mask <= `CAS_MASK_RESET;
    end else if (wr_mask) begin
      mask <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      lane_alarm <= LANES'(`CAS_LANE_RESET);
    end else if (i_clock_en) begin
      lane_alarm <= (lane_alarm & ~(wr_lane ? i_pwdata[LANES-1:0]
                                            : '0)
                                & ~{LANES{fifo_clr}}) | lane_err;
    end
  end

  logic summary;
  assign summary         = |(flags & ~mask & `CAS_FLAGS_WMASK);
  assign o_summary_alarm = summary;

  // ----------------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------------
  logic [`CAS_IRQ_BITS-1:0] irq_status;
  logic [`CAS_IRQ_BITS-1:0] irq_enable;
  logic [`CAS_IRQ_BITS-1:0] irq_event;
  logic [`CAS_IRQ_BITS-1:0] irq_clr;
  logic                     summary_q;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      summary_q <= 1'b0;
    end else if (i_clock_en) begin
      summary_q <= summary;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`CAS_IRQ_SUMMARY]  = summary && !summary_q;
    irq_event[`CAS_IRQ_FLAG_SET] = |(flag_set & ~flags);
    irq_event[`CAS_IRQ_LANE_SET] = |(lane_err & ~lane_alarm);
  end

  assign irq_clr = wr_irq_clr ? i_pwdata[`CAS_IRQ_BITS-1:0] : '0;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_status <= '0;
    end else if (i_clock_en) begin
      irq_status <= (irq_status & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_enable <= '0;
    end else if (wr_irq_en) begin
      irq_enable <= i_pwdata[`CAS_IRQ_BITS-1:0];
    end
  end

  assign o_irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(i_paddr, `CAS_IDX_SUMMARY)) begin
      rdata[0] = summary;
    end else if (hit(i_paddr, `CAS_IDX_FLAGS)) begin
      rdata[7:0] = flags;
    end else if (hit(i_paddr, `CAS_IDX_MASK)) begin
      rdata[7:0] = mask;
    end else if (hit(i_paddr, `CAS_IDX_LANE)) begin
      rdata[LANES-1:0] = lane_alarm;
    end else if (hit(i_paddr, `CAS_IDX_IRQ_STATUS)) begin
      rdata[`CAS_IRQ_BITS-1:0] = irq_status;
    end else if (hit(i_paddr, `CAS_IDX_IRQ_ENABLE)) begin
      rdata[`CAS_IRQ_BITS-1:0] = irq_enable;
    end else if (hit(i_paddr, `CAS_IDX_CONTROL)) begin
      rdata[`CAS_CTL_LINK_EN]  = link_en;
      rdata[`CAS_CTL_MODE_66B] = mode_66b;
    end
  end

  // read data registered in the setup cycle so it is stable in access
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_clock_en && i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rdata;
    end
  end

endmodule : cas_alarm

// ---- tb/cas_alarm_properties.sv ----
// port checker for the alarm block
`timescale 1ns/1ps
`include "cas_consts.svh"
module cas_alarm_properties (
  // clock and control
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_clock_en,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // alarm outputs
  input wire logic        o_summary_alarm,
  input wire logic        o_serial_link_enable,
  input wire logic        o_irq
);
  localparam logic [11:0] adr_flags = {`CAS_IDX_FLAGS, 2'b00};
  localparam logic [11:0] adr_mask  = {`CAS_IDX_MASK, 2'b00};
  localparam logic [11:0] adr_ctl   = {`CAS_IDX_CONTROL, 2'b00};
  localparam logic [11:0] adr_ien   = {`CAS_IDX_IRQ_ENABLE, 2'b00};
  logic acc;
  logic untouched;
  logic armed;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  assign acc = i_psel && i_penable && i_clock_en;
  // ----------------------------------------------------------------
  // flags still at reset value, interrupt enable non-zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst)
      untouched <= 1'b1;
    else if (acc && i_pwrite && i_paddr == adr_flags)
      untouched <= 1'b0;
  end
  always_ff @(posedge i_clock) begin
    if (i_srst)
      armed <= 1'b0;
    else if (acc && i_pwrite && i_paddr == adr_ien)
      armed <= |i_pwdata[2:0];
  end
  a_reset_quiet: assert property ($past(i_srst) |-> !o_summary_alarm)
    else $error("summary high after reset");
  a_flags_reset: assert property (acc && i_pwrite
    && i_paddr == adr_mask && untouched
    && (i_pwdata[5:2] != 4'hf || !i_pwdata[0])
    |=> o_summary_alarm) else $error("reset flags not reaching summary");
  a_mask_blocks: assert property (acc && i_pwrite
    && i_paddr == adr_mask
    && i_pwdata[5:2] == 4'hf && i_pwdata[0] |=> !o_summary_alarm)
    else $error("masked flags reach summary");
  a_link_enable: assert property (acc && i_pwrite
    && i_paddr == adr_ctl
    |=> o_serial_link_enable == $past(i_pwdata[0]))
    else $error("link enable not written");
  a_clock_freeze: assert property (!i_clock_en
    |=> $stable(o_serial_link_enable)) else $error("state moved while frozen");
  a_irq_quiet: assert property (!armed |-> !o_irq)
    else $error("irq high with enable clear");
  a_slverr_odd: assert property (i_psel && i_penable && i_paddr[1:0] != 2'b00
    |-> o_pslverr) else $error("unaligned access not refused");
  a_err_zero: assert property (acc && $past(i_clock_en) && !i_pwrite
    && o_pslverr |-> o_prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_pready_high: assert property (o_pready) else $error("pready low");
endmodule : cas_alarm_properties

bind cas_alarm cas_alarm_properties chk (
  .i_clock(i_clock), .i_srst(i_srst), .i_clock_en(i_clock_en),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_summary_alarm(o_summary_alarm),
  .o_serial_link_enable(o_serial_link_enable), .o_irq(o_irq)
);

// ---- tb/cas_alarm_bench.sv ----
// self-checking bench for the alarm block
`timescale 1ns/1ps
`include "cas_consts.svh"
module cas_alarm_bench;
  localparam logic [11:0] a_sum = {`CAS_IDX_SUMMARY, 2'b00};
  localparam logic [11:0] a_flg = {`CAS_IDX_FLAGS, 2'b00};
  localparam logic [11:0] a_msk = {`CAS_IDX_MASK, 2'b00};
  localparam logic [11:0] a_lan = {`CAS_IDX_LANE, 2'b00};
  localparam logic [11:0] a_ist = {`CAS_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] a_ien = {`CAS_IDX_IRQ_ENABLE, 2'b00};
  localparam logic [11:0] a_icl = {`CAS_IDX_IRQ_CLEAR, 2'b00};
  localparam logic [11:0] a_ctl = {`CAS_IDX_CONTROL, 2'b00};
  localparam logic [13:0] idle  = 14'h3000;
  logic                 i_clock, i_srst, i_clock_en;
  logic                 i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0]          i_paddr;
  logic [31:0]          i_pwdata, o_prdata, rdat;
  cas_pkg::cas_events_s i_events;
  logic [7:0]           i_lane_active;
  logic                 o_summary_alarm, o_serial_link_enable, o_irq, rerr;
  int                   miscompares = 0;
  int                   n_compared = 0;

  cas_alarm #(.LANES(8)) uut (
    .i_clock(i_clock), .i_srst(i_srst), .i_clock_en(i_clock_en),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_events(i_events),
    .i_lane_active(i_lane_active), .o_summary_alarm(o_summary_alarm),
    .o_serial_link_enable(o_serial_link_enable), .o_irq(o_irq)
  );

  always #25 i_clock = ~i_clock;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] s, input logic [31:0] e,
                     input string w);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] adr,
                     input logic [7:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= adr;
    i_pwdata <= {24'h00_0000, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb

  task automatic wr(input logic [11:0] adr, input logic [7:0] d);
    apb(1'b1, adr, d, rdat, rerr);
  endtask : wr

  task automatic rd(input logic [11:0] adr, input logic [7:0] e,
                    input string w);
    apb(1'b0, adr, 8'h00, rdat, rerr);
    chk(rdat, {24'h00_0000, e}, w);
  endtask : rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(a_flg, 8'h3f, "flags");
    rd(a_msk, 8'h3f, "mask");
    rd(a_lan, 8'hff, "lane");
    chk(o_summary_alarm, 1'b0, "summary");
    apb(1'b0, 12'hffc, 8'h00, rdat, rerr);
    chk({rerr, rdat[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b1, a_flg + 12'h001, 8'h3f, rdat, rerr);
    chk(rerr, 1'b1, "unaligned write");
    rd(a_flg, 8'h3f, "flags");
  endtask : t_reset

  task automatic t_mask();
    int b[5] = '{5, 4, 3, 2, 0};
    foreach (b[k]) begin
      wr(a_msk, 8'h3f ^ (8'h01 << b[k]));
      chk(o_summary_alarm, 1'b1, "summary");
      rd(a_sum, 8'h01, "summary reg");
      wr(a_msk, 8'h3f);
      chk(o_summary_alarm, 1'b0, "summary");
    end
    wr(a_flg, 8'hff);
    rd(a_flg, 8'h02, "flags");
    rd(a_lan, 8'h00, "lane");
  endtask : t_mask

  task automatic t_link();
    i_events <= 14'h1100;
    repeat (10) @(posedge i_clock);
    rd(a_flg, 8'h03, "flags link off");
    i_events <= idle;
    repeat (10) @(posedge i_clock);
    i_clock_en <= 1'b0;
    wr(a_ctl, 8'h01);
    chk(o_serial_link_enable, 1'b0, "frozen enable");
    i_clock_en <= 1'b1;
    wr(a_ctl, 8'h01);
    chk(o_serial_link_enable, 1'b1, "link enable");
    wr(a_flg, 8'h3f);
  endtask : t_link

  task automatic t_events();
    logic [13:0] ev[5] = '{14'h1000, 14'h2000, 14'h3200, 14'h3100, 14'h3081};
    logic [7:0]  ex[5] = '{8'h12, 8'h0a, 8'h06, 8'h03, 8'h22};
    i_lane_active <= 8'h0f;
    foreach (ev[k]) begin
      i_events <= ev[k];
      repeat (10) @(posedge i_clock);
      rd(a_flg, ex[k], "flags");
      if (k == 4)
        rd(a_lan, 8'h01, "lane");
      wr(a_flg, 8'h3f);
      rd(a_flg, ex[k], "flags");
      i_events <= idle;
      repeat (10) @(posedge i_clock);
      if (k == 4) begin
        wr(a_lan, 8'h01);
        rd(a_lan, 8'h00, "lane clear");
      end
      wr(a_flg, 8'h3f);
      rd(a_flg, 8'h02, "flags");
    end
  endtask : t_events

  task automatic t_wide();
    wr(a_ctl, 8'h00);
    wr(a_flg, 8'h3f);
    wr(a_ctl, 8'h03);
    rd(a_flg, 8'h0a, "flags");
    wr(a_flg, 8'h3f);
    i_events <= 14'h3400;
    repeat (10) @(posedge i_clock);
    rd(a_flg, 8'h0a, "flags");
    wr(a_flg, 8'h3f);
    i_events <= 14'h3800;
    repeat (10) @(posedge i_clock);
    rd(a_flg, 8'h0a, "flags startup");
    i_events <= idle;
  endtask : t_wide

  task automatic t_irq();
    wr(a_flg, 8'h3f);
    wr(a_icl, 8'h07);
    wr(a_ien, 8'h02);
    i_events <= 14'h3100;
    repeat (10) @(posedge i_clock);
    chk(o_irq, 1'b1, "irq");
    rd(a_ist, 8'h02, "irq status");
    wr(a_ien, 8'h00);
    chk(o_irq, 1'b0, "irq masked");
    wr(a_icl, 8'h02);
    wr(a_ien, 8'h02);
    chk(o_irq, 1'b0, "irq cleared");
    rd(a_ien, 8'h02, "irq enable");
    rd(a_ctl, 8'h03, "control");
    wr(a_ien, 8'h01);
    wr(a_msk, 8'h3e);
    rd(a_ist, 8'h01, "irq summary status");
    chk(o_irq, 1'b1, "irq summary");
    wr(a_msk, 8'h3f);
    i_events <= idle;
  endtask : t_irq

  initial begin
    i_clock = 1'b0;
    i_srst = 1'b1;
    i_clock_en = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    i_events = idle;
    i_lane_active = 8'hff;
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_mask();
    t_link();
    t_events();
    t_wide();
    t_irq();
    close_out();
  end
endmodule : cas_alarm_bench
